// ### pkg/spief_pkg.sv
`default_nettype none
package spief_pkg;
	localparam int DATA_W = 8;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int SYNC_W = 4;
	localparam int SIG_SCK = 0;
	localparam int SIG_MOSI = 1;
	localparam int SIG_MISO = 2;
	localparam int SIG_SS = 3;
	// Target select idles high, data lines idle low
	localparam logic [SYNC_W-1:0] SYNC_INIT = 4'h8;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCK_HALF_NS = 40;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : SCK_HALF_NS / CLK_PERIOD_NS;
	localparam int DIV_W = 8;
	localparam logic RST_FLAG = 1'b0;
	localparam logic RST_SOFT_LEVEL = 1'b0;
	localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
	typedef enum logic {
		ST_IDLE,
		ST_SHIFT
	} spief_state_type;
endpackage
`default_nettype wire

// ### pkg/spief_sig_if.sv
`timescale 1ns/100ps
`default_nettype none
interface spief_sig_if #(
	parameter int W = 4
);
	logic [W-1:0] lvl;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// ### logic/spief_sync.sv
`timescale 1ns/100ps
`default_nettype none
module spief_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] raw_i,
	spief_sig_if.src sig
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
	logic [W-1:0] nxt_lvl;

	if (W < 1) begin
		$error("spief_sync needs at least one line");
	end

	// A change counts only once the second and third stages agree
	always_comb begin
		nxt_lvl = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & lvl_ff);
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			s1_ff <= INIT;
			s2_ff <= INIT;
			s3_ff <= INIT;
			lvl_ff <= INIT;
			rise_ff <= '0;
			fall_ff <= '0;
		end else begin
			s1_ff <= raw_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			lvl_ff <= nxt_lvl;
			rise_ff <= nxt_lvl & ~lvl_ff;
			fall_ff <= ~nxt_lvl & lvl_ff;
		end
	end

	assign sig.lvl = lvl_ff;
	assign sig.rise = rise_ff;
	assign sig.fall = fall_ff;
endmodule
`default_nettype wire

// ### logic/spief_top.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Master with select pulled low sets the fault flag, interrupt if enabled.
// - A master fault clears port enable and master select, stopping all outputs.
// - Fault flag clears after status read while set, then control write.
// - While fault flag set, setting enable or master is refused except clearing write.
// - Fault flag is never set in slave mode but may stay set there.
// - Byte completing while done flag still set sets overrun, interrupt if enabled.
// - After overrun the read buffer keeps the first byte; later bytes are dropped.
// - Overrun flag clears on a status register read.
// - Data write during a transfer is dropped, transfer continues, clash flag set.
// - The clash flag never raises an interrupt.
// - Received bytes go to a separate read buffer, never the live shifter.
// - Wait mode leaves operation alone; any enabled event requests wake-up.
// - Halt ignores CPU strobes and freezes master shifting; repeated slave bytes in halt set overrun if select was low at entry.
// - In slave mode only a done interrupt wakes from halt.
// - Halt wake-up only if effective select was low at halt entry.
// - Done, fault and overrun share one request, gated by enable and CPU mask.
// - A slave with no new data shifts its last received byte back out.
// - Done flag clears after status access then data read or write.
// - Bytes are shifted most significant bit first.
// - Soft select mode takes internal select from the soft level bit.
module spief_top #(
	parameter int HALF_CYC = spief_pkg::SCK_HALF_CYC
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic cr_wr_i,
	input wire logic cr_irq_en_i,
	input wire logic cr_periph_on_i,
	input wire logic cr_ctrl_sel_i,
	input wire logic csr_rd_i,
	input wire logic csr_wr_i,
	input wire logic csr_soft_mode_i,
	input wire logic csr_soft_level_i,
	input wire logic csr_out_dis_i,
	input wire logic dr_rd_i,
	input wire logic dr_wr_i,
	input wire logic [spief_pkg::DATA_W-1:0] dr_wdata_i,
	input wire logic cpu_irq_mask_i,
	input wire logic wait_mode_i,
	input wire logic halt_mode_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	input wire logic target_select_n_i,
	output logic sck_o,
	output logic sck_oe_o,
	output logic mosi_o,
	output logic mosi_oe_o,
	output logic miso_o,
	output logic miso_oe_o,
	output logic [spief_pkg::DATA_W-1:0] dr_rdata_o,
	output logic transfer_done_flag_o,
	output logic write_clash_flag_o,
	output logic overrun_flag_o,
	output logic master_fault_flag_o,
	output logic peripheral_on_o,
	output logic controller_select_o,
	output logic spi_irq_enable_o,
	output logic soft_select_mode_o,
	output logic soft_select_level_o,
	output logic spi_irq_o,
	output logic wake_req_o
);
	import spief_pkg::*;

	spief_sig_if #(.W(SYNC_W)) pins ();

	spief_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.raw_i({target_select_n_i, miso_i, mosi_i, sck_i}),
		.sig(pins.src)
	);

	if (HALF_CYC < 1 || HALF_CYC > 255) begin
		$error("HALF_CYC must lie in 1..255");
	end

	spief_state_type state_ff, nxt_state;
	logic spi_irq_enable_ff, spe_ff, controller_select_ff, ssm_ff, ssi_ff, sod_ff;
	logic nxt_spi_irq_enable, nxt_spe, nxt_controller_select, nxt_ssm, nxt_ssi, nxt_sod;
	logic transfer_done_flag_ff, write_clash_flag_ff, ovr_ff, master_fault_flag_ff;
	logic nxt_transfer_done_flag, nxt_write_clash_flag, nxt_ovr, nxt_master_fault_flag;
	logic transfer_done_flag_arm_ff, write_clash_flag_arm_ff, master_fault_flag_arm_ff;
	logic nxt_transfer_done_flag_arm, nxt_write_clash_flag_arm, nxt_master_fault_flag_arm;
	logic [DATA_W-1:0] shift_ff, nxt_shift, rxbuf_ff, nxt_rxbuf;
	logic [3:0] bitcnt_ff, nxt_bitcnt;
	logic [DIV_W-1:0] div_ff, nxt_div;
	logic sck_ff, nxt_sck, in_bit_ff, nxt_in_bit;
	logic halt_d_ff, halt_ok_ff, nxt_halt_ok;
	logic irq_ff, nxt_irq, wake_ff, nxt_wake;
	logic mosi_ff, mosi_oe_ff, miso_ff, miso_oe_ff, sck_oe_ff;
	logic nxt_mosi_oe, nxt_miso_oe, nxt_sck_oe;

	logic ss_eff, slave_sel, active, shift_ev, capture_ev, done, irq_cond;
	logic [DATA_W-1:0] shifted;

	always_comb begin
		ss_eff = ssm_ff ? ssi_ff : pins.lvl[SIG_SS];
		slave_sel = spe_ff & ~controller_select_ff & ~ss_eff;
		active = (state_ff == ST_SHIFT) | (slave_sel & (bitcnt_ff != 4'h0));
		shift_ev = 1'b0;
		capture_ev = 1'b0;
		done = 1'b0;
		nxt_state = state_ff;
		nxt_spi_irq_enable = spi_irq_enable_ff;
		nxt_spe = spe_ff;
		nxt_controller_select = controller_select_ff;
		nxt_ssm = ssm_ff;
		nxt_ssi = ssi_ff;
		nxt_sod = sod_ff;
		nxt_transfer_done_flag = transfer_done_flag_ff;
		nxt_write_clash_flag = write_clash_flag_ff;
		nxt_ovr = ovr_ff;
		nxt_master_fault_flag = master_fault_flag_ff;
		nxt_transfer_done_flag_arm = transfer_done_flag_arm_ff;
		nxt_write_clash_flag_arm = write_clash_flag_arm_ff;
		nxt_master_fault_flag_arm = master_fault_flag_arm_ff;
		nxt_shift = shift_ff;
		nxt_rxbuf = rxbuf_ff;
		nxt_bitcnt = bitcnt_ff;
		nxt_div = div_ff;
		nxt_sck = sck_ff;
		nxt_in_bit = in_bit_ff;
		nxt_halt_ok = halt_ok_ff;

		// CPU is stopped in halt, so its strobes are ignored there
		if (!halt_mode_i) begin
			if (csr_rd_i) begin
				nxt_ovr = 1'b0;
				nxt_master_fault_flag_arm = master_fault_flag_ff | master_fault_flag_arm_ff;
				nxt_write_clash_flag_arm = write_clash_flag_ff | write_clash_flag_arm_ff;
			end
			if (csr_rd_i || csr_wr_i) begin
				nxt_transfer_done_flag_arm = transfer_done_flag_ff | transfer_done_flag_arm_ff;
			end
			if (csr_wr_i) begin
				nxt_ssm = csr_soft_mode_i;
				nxt_ssi = csr_soft_level_i;
				nxt_sod = csr_out_dis_i;
			end
			if (cr_wr_i) begin
				nxt_spi_irq_enable = cr_irq_en_i;
				if (master_fault_flag_ff && !master_fault_flag_arm_ff) begin
					nxt_spe = spe_ff & cr_periph_on_i;
					nxt_controller_select = controller_select_ff & cr_ctrl_sel_i;
				end else begin
					nxt_spe = cr_periph_on_i;
					nxt_controller_select = cr_ctrl_sel_i;
				end
				if (master_fault_flag_arm_ff) begin
					nxt_master_fault_flag = 1'b0;
					nxt_master_fault_flag_arm = 1'b0;
				end
			end
			if (dr_rd_i || dr_wr_i) begin
				if (transfer_done_flag_arm_ff) begin
					nxt_transfer_done_flag = 1'b0;
					nxt_transfer_done_flag_arm = 1'b0;
				end
				if (write_clash_flag_arm_ff) begin
					nxt_write_clash_flag = 1'b0;
					nxt_write_clash_flag_arm = 1'b0;
				end
			end
			if (dr_wr_i) begin
				if (active) begin
					nxt_write_clash_flag = 1'b1;
				end else if (!transfer_done_flag_ff || transfer_done_flag_arm_ff) begin
					nxt_shift = dr_wdata_i;
					nxt_bitcnt = 4'h0;
					if (controller_select_ff && spe_ff) begin
						nxt_state = ST_SHIFT;
						nxt_div = '0;
					end
				end
			end
		end

		// Master clocking pauses in halt and picks up where it stopped
		if (state_ff == ST_SHIFT && !halt_mode_i) begin
			if (div_ff == DIV_W'(HALF_CYC - 1)) begin
				nxt_div = '0;
				nxt_sck = ~sck_ff;
				capture_ev = ~sck_ff;
				shift_ev = sck_ff;
			end else begin
				nxt_div = div_ff + DIV_W'(1);
			end
		end else if (slave_sel && (!halt_mode_i || halt_ok_ff)) begin
			capture_ev = pins.rise[SIG_SCK];
			shift_ev = pins.fall[SIG_SCK];
		end else if (!controller_select_ff && ss_eff) begin
			nxt_bitcnt = 4'h0;
		end

		if (capture_ev) begin
			nxt_in_bit = controller_select_ff ? pins.lvl[SIG_MISO] : pins.lvl[SIG_MOSI];
		end
		// Leftover content recirculates, so an unloaded slave echoes its last byte
		shifted = {shift_ff[DATA_W-2:0], in_bit_ff};
		if (shift_ev) begin
			nxt_shift = shifted;
			nxt_bitcnt = bitcnt_ff + 4'h1;
			if (bitcnt_ff + 4'h1 == BITS_PER_BYTE) begin
				done = 1'b1;
				nxt_bitcnt = 4'h0;
				nxt_state = ST_IDLE;
				nxt_sck = 1'b0;
			end
		end
		if (done) begin
			if (nxt_transfer_done_flag) begin
				nxt_ovr = 1'b1;
			end else begin
				nxt_rxbuf = shifted;
				nxt_transfer_done_flag = 1'b1;
				nxt_transfer_done_flag_arm = 1'b0;
			end
		end

		// Fault comes last so it beats any software set or clear in the same cycle
		if (controller_select_ff && !ss_eff) begin
			nxt_master_fault_flag = 1'b1;
			nxt_master_fault_flag_arm = 1'b0;
			nxt_spe = 1'b0;
			nxt_controller_select = 1'b0;
			nxt_state = ST_IDLE;
			nxt_sck = 1'b0;
			nxt_bitcnt = 4'h0;
		end

		if (halt_mode_i && !halt_d_ff) begin
			nxt_halt_ok = ~ss_eff;
		end

		irq_cond = spi_irq_enable_ff & ~cpu_irq_mask_i & (transfer_done_flag_ff | ovr_ff | master_fault_flag_ff);
		nxt_irq = irq_cond;
		nxt_wake = (wait_mode_i & irq_cond) |
			(halt_mode_i & halt_ok_ff & ~controller_select_ff & spi_irq_enable_ff & ~cpu_irq_mask_i & transfer_done_flag_ff);

		nxt_sck_oe = nxt_spe & nxt_controller_select;
		nxt_mosi_oe = nxt_spe & nxt_controller_select & ~nxt_sod;
		nxt_miso_oe = nxt_spe & ~nxt_controller_select & ~ss_eff & ~nxt_sod;
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_ff <= ST_IDLE;
			spi_irq_enable_ff <= RST_FLAG;
			spe_ff <= RST_FLAG;
			controller_select_ff <= RST_FLAG;
			ssm_ff <= RST_FLAG;
			ssi_ff <= RST_SOFT_LEVEL;
			sod_ff <= RST_FLAG;
			transfer_done_flag_ff <= RST_FLAG;
			write_clash_flag_ff <= RST_FLAG;
			ovr_ff <= RST_FLAG;
			master_fault_flag_ff <= RST_FLAG;
			transfer_done_flag_arm_ff <= RST_FLAG;
			write_clash_flag_arm_ff <= RST_FLAG;
			master_fault_flag_arm_ff <= RST_FLAG;
			shift_ff <= RST_DATA;
			rxbuf_ff <= RST_DATA;
			bitcnt_ff <= 4'h0;
			div_ff <= '0;
			sck_ff <= 1'b0;
			in_bit_ff <= 1'b0;
			halt_d_ff <= 1'b0;
			halt_ok_ff <= 1'b0;
			irq_ff <= 1'b0;
			wake_ff <= 1'b0;
			mosi_ff <= 1'b0;
			miso_ff <= 1'b0;
			sck_oe_ff <= 1'b0;
			mosi_oe_ff <= 1'b0;
			miso_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			spi_irq_enable_ff <= nxt_spi_irq_enable;
			spe_ff <= nxt_spe;
			controller_select_ff <= nxt_controller_select;
			ssm_ff <= nxt_ssm;
			ssi_ff <= nxt_ssi;
			sod_ff <= nxt_sod;
			transfer_done_flag_ff <= nxt_transfer_done_flag;
			write_clash_flag_ff <= nxt_write_clash_flag;
			ovr_ff <= nxt_ovr;
			master_fault_flag_ff <= nxt_master_fault_flag;
			transfer_done_flag_arm_ff <= nxt_transfer_done_flag_arm;
			write_clash_flag_arm_ff <= nxt_write_clash_flag_arm;
			master_fault_flag_arm_ff <= nxt_master_fault_flag_arm;
			shift_ff <= nxt_shift;
			rxbuf_ff <= nxt_rxbuf;
			bitcnt_ff <= nxt_bitcnt;
			div_ff <= nxt_div;
			sck_ff <= nxt_sck;
			in_bit_ff <= nxt_in_bit;
			halt_d_ff <= halt_mode_i;
			halt_ok_ff <= nxt_halt_ok;
			irq_ff <= nxt_irq;
			wake_ff <= nxt_wake;
			mosi_ff <= nxt_shift[DATA_W-1];
			miso_ff <= nxt_shift[DATA_W-1];
			sck_oe_ff <= nxt_sck_oe;
			mosi_oe_ff <= nxt_mosi_oe;
			miso_oe_ff <= nxt_miso_oe;
		end
	end

	assign sck_o = sck_ff;
	assign sck_oe_o = sck_oe_ff;
	assign mosi_o = mosi_ff;
	assign mosi_oe_o = mosi_oe_ff;
	assign miso_o = miso_ff;
	assign miso_oe_o = miso_oe_ff;
	assign dr_rdata_o = rxbuf_ff;
	assign transfer_done_flag_o = transfer_done_flag_ff;
	assign write_clash_flag_o = write_clash_flag_ff;
	assign overrun_flag_o = ovr_ff;
	assign master_fault_flag_o = master_fault_flag_ff;
	assign peripheral_on_o = spe_ff;
	assign controller_select_o = controller_select_ff;
	assign spi_irq_enable_o = spi_irq_enable_ff;
	assign soft_select_mode_o = ssm_ff;
	assign soft_select_level_o = ssi_ff;
	assign spi_irq_o = irq_ff;
	assign wake_req_o = wake_ff;
endmodule
`default_nettype wire

// ### bench/spief_sva.sv
`timescale 1ns/100ps
`default_nettype none
module spief_sva (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic csr_rd_i,
	input wire logic dr_rd_i,
	input wire logic dr_wr_i,
	input wire logic halt_mode_i,
	input wire logic cpu_irq_mask_i,
	input wire logic [spief_pkg::DATA_W-1:0] dr_rdata_o,
	input wire logic transfer_done_flag_o,
	input wire logic write_clash_flag_o,
	input wire logic overrun_flag_o,
	input wire logic master_fault_flag_o,
	input wire logic peripheral_on_o,
	input wire logic controller_select_o,
	input wire logic spi_irq_enable_o,
	input wire logic spi_irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	a_irq_merge: assert property (spi_irq_o == $past(spi_irq_enable_o && !cpu_irq_mask_i
		&& (transfer_done_flag_o || overrun_flag_o || master_fault_flag_o))) else $error("irq request wrong");
	a_clash_silent: assert property ($rose(write_clash_flag_o) && !transfer_done_flag_o
		&& !overrun_flag_o && !master_fault_flag_o |=> !spi_irq_o) else $error("clash raised irq");
	a_fault_stops: assert property ($rose(master_fault_flag_o)
		|-> !peripheral_on_o && !controller_select_o) else $error("fault left port on");
	a_fault_master: assert property ($rose(master_fault_flag_o)
		|-> $past(controller_select_o)) else $error("fault set in slave mode");
	a_ovr_cause: assert property ($rose(overrun_flag_o)
		|-> $past(transfer_done_flag_o)) else $error("overrun without done");
	a_ovr_holds: assert property ($rose(overrun_flag_o)
		|-> $stable(dr_rdata_o)) else $error("read buffer overwritten");
	a_ovr_clear: assert property (csr_rd_i && !halt_mode_i && overrun_flag_o
		|=> !overrun_flag_o) else $error("overrun not cleared");
	a_done_clear: assert property ($fell(transfer_done_flag_o)
		|-> $past(dr_rd_i || dr_wr_i)) else $error("done cleared early");
endmodule
bind spief_top spief_sva spief_sva_inst (.*);
`default_nettype wire

// ### bench/spief_peer.sv
`timescale 1ns/100ps
`default_nettype none
module spief_peer (
	output var logic sck_o,
	output var logic mosi_o,
	output var logic ss_n_o,
	input wire logic miso_i
);
	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		ss_n_o = 1'b1;
	end
	// Single slave on this link, so one select line is all there is
	task automatic sel(input logic v);
		ss_n_o = v;
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		ss_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#80;
			sck_o = 1'b1;
			rx[i] = miso_i;
			#80;
			sck_o = 1'b0;
		end
		#80;
		ss_n_o = 1'b1;
		// Released line must not keep looking like valid data
		mosi_o = ~tx[0];
	endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import spief_pkg::*;
	logic clk_sys_i, sys_rst_i, cr_wr_i, cr_irq_en_i, cr_periph_on_i, cr_ctrl_sel_i, csr_rd_i, csr_wr_i;
	logic csr_soft_mode_i, csr_soft_level_i, csr_out_dis_i, dr_rd_i, dr_wr_i, cpu_irq_mask_i;
	logic wait_mode_i, halt_mode_i, sck_i, mosi_i, miso_i, target_select_n_i, sck_o, sck_oe_o;
	logic mosi_o, mosi_oe_o, miso_o, miso_oe_o, transfer_done_flag_o, write_clash_flag_o, overrun_flag_o;
	logic master_fault_flag_o, peripheral_on_o, controller_select_o, spi_irq_enable_o;
	logic soft_select_mode_o, soft_select_level_o, spi_irq_o, wake_req_o;
	logic [DATA_W-1:0] dr_wdata_i, dr_rdata_o, rx, mtx;
	logic sck_q;
	int n_mismatch, n_compared;
	// Undriven line toggles with the clock so stale data cannot pass
	assign miso_i = miso_oe_o ? miso_o : ~sck_i;
	// Collects what the block drives out as master, one bit per rising link clock
	always @(negedge clk_sys_i) begin
		sck_q <= sck_o;
		if (sck_o && !sck_q) begin
			mtx <= {mtx[DATA_W-2:0], mosi_o};
		end
	end
	spief_peer spief_peer_inst (.sck_o(sck_i), .mosi_o(mosi_i), .ss_n_o(target_select_n_i), .miso_i(miso_i));
	spief_top #(.HALF_CYC(1)) spief_top_inst (.*);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk_sys_i);
		s = 1'b1;
		@(negedge clk_sys_i);
		s = 1'b0;
	endtask
	task automatic cr(input logic e, input logic o, input logic s);
		cr_irq_en_i = e;
		cr_periph_on_i = o;
		cr_ctrl_sel_i = s;
		pulse(cr_wr_i);
	endtask
	task automatic wt(ref logic f);
		int k;
		for (k = 0; k < 400 && f !== 1'b1; k++) begin
			@(negedge clk_sys_i);
		end
		if (k == 400) begin
			n_mismatch++;
			$display("[FAIL] %0t wait timed out", $time);
			stop_test();
		end
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		{sys_rst_i, cr_wr_i, cr_irq_en_i, cr_periph_on_i, cr_ctrl_sel_i, csr_rd_i, csr_wr_i} = 7'h40;
		{csr_soft_mode_i, csr_soft_level_i, csr_out_dis_i, dr_rd_i, dr_wr_i} = 5'h00;
		{cpu_irq_mask_i, wait_mode_i, halt_mode_i} = 3'h0;
		dr_wdata_i = 8'h00;
		n_mismatch = 0;
		n_compared = 0;
		repeat (6) @(negedge clk_sys_i);
		sys_rst_i = 1'b0;
		chk({4'h0, peripheral_on_o, spi_irq_enable_o, master_fault_flag_o, spi_irq_o}, 8'h00);
		cr(1'b1, 1'b1, 1'b0);
		dr_wdata_i = 8'h5a;
		pulse(dr_wr_i);
		wait_mode_i = 1'b1;
		spief_peer_inst.xfer(8'ha5, rx);
		chk(rx, 8'h5a);
		wt(transfer_done_flag_o);
		repeat (2) @(negedge clk_sys_i);
		chk({4'h0, spi_irq_o, wake_req_o, overrun_flag_o, write_clash_flag_o}, 8'h0c);
		chk(dr_rdata_o, 8'ha5);
		$display("end slave_rx");
		wait_mode_i = 1'b0;
		spief_peer_inst.xfer(8'h3c, rx);
		chk(rx, 8'ha5);
		wt(overrun_flag_o);
		chk(dr_rdata_o, 8'ha5);
		cpu_irq_mask_i = 1'b1;
		pulse(csr_rd_i);
		chk({7'h0, overrun_flag_o}, 8'h00);
		pulse(dr_rd_i);
		chk({6'h0, transfer_done_flag_o, spi_irq_o}, 8'h00);
		$display("end overrun");
		cpu_irq_mask_i = 1'b0;
		fork
			spief_peer_inst.xfer(8'h0f, rx);
			begin
				#400;
				dr_wdata_i = 8'hc3;
				pulse(dr_wr_i);
				wt(write_clash_flag_o);
				repeat (2) @(negedge clk_sys_i);
				chk({7'h0, spi_irq_o}, 8'h00);
			end
		join
		chk(rx, 8'h3c);
		wt(transfer_done_flag_o);
		pulse(csr_rd_i);
		pulse(dr_rd_i);
		chk({6'h0, write_clash_flag_o, transfer_done_flag_o}, 8'h00);
		$display("end clash");
		cr(1'b1, 1'b1, 1'b1);
		spief_peer_inst.sel(1'b0);
		wt(master_fault_flag_o);
		repeat (2) @(negedge clk_sys_i);
		chk({4'h0, peripheral_on_o, controller_select_o, master_fault_flag_o, spi_irq_o}, 8'h03);
		cr(1'b1, 1'b1, 1'b1);
		chk({6'h0, peripheral_on_o, controller_select_o}, 8'h00);
		spief_peer_inst.sel(1'b1);
		repeat (8) @(negedge clk_sys_i);
		pulse(csr_rd_i);
		cr(1'b1, 1'b1, 1'b1);
		chk({5'h0, peripheral_on_o, controller_select_o, master_fault_flag_o}, 8'h06);
		$display("end fault");
		dr_wdata_i = 8'h96;
		pulse(dr_wr_i);
		wt(transfer_done_flag_o);
		chk({4'h0, sck_o, sck_oe_o, mosi_oe_o, miso_oe_o}, 8'h06);
		chk(mtx, 8'h96);
		chk(dr_rdata_o, 8'hff);
		// Done flag set with no status access since, so this load must not start a byte
		dr_wdata_i = 8'h11;
		pulse(dr_wr_i);
		repeat (3) @(negedge clk_sys_i);
		chk({5'h0, sck_o, write_clash_flag_o, transfer_done_flag_o}, 8'h01);
		$display("end master");
		csr_soft_mode_i = 1'b1;
		csr_soft_level_i = 1'b1;
		pulse(csr_wr_i);
		pulse(dr_rd_i);
		chk({5'h0, soft_select_mode_o, soft_select_level_o, transfer_done_flag_o}, 8'h06);
		cr(1'b1, 1'b1, 1'b0);
		csr_soft_level_i = 1'b0;
		pulse(csr_wr_i);
		repeat (2) @(negedge clk_sys_i);
		chk({6'h0, miso_oe_o, peripheral_on_o}, 8'h03);
		halt_mode_i = 1'b1;
		spief_peer_inst.xfer(8'h69, rx);
		chk(rx, 8'hff);
		wt(transfer_done_flag_o);
		repeat (2) @(negedge clk_sys_i);
		chk({6'h0, wake_req_o, spi_irq_o}, 8'h03);
		halt_mode_i = 1'b0;
		chk(dr_rdata_o, 8'h69);
		pulse(csr_rd_i);
		pulse(dr_rd_i);
		spief_peer_inst.xfer(8'h12, rx);
		chk(rx, 8'h69);
		wt(transfer_done_flag_o);
		pulse(csr_rd_i);
		pulse(dr_rd_i);
		// Pin select is high at halt entry, so the byte below must be ignored
		csr_soft_mode_i = 1'b0;
		pulse(csr_wr_i);
		halt_mode_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		spief_peer_inst.xfer(8'h3c, rx);
		repeat (8) @(negedge clk_sys_i);
		chk({6'h0, transfer_done_flag_o, wake_req_o}, 8'h00);
		halt_mode_i = 1'b0;
		$display("end halt");
		stop_test();
	end
endmodule
`default_nettype wire
